// >>> design/watch_pkg.sv
// Constants shared by the watch timer and its sub-blocks
package watch_pkg;

   // ***************************************************************
   // Register map (16-bit byte addresses)
   // ***************************************************************
   localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hff42; // timer_clock_select_two
   localparam logic [15:0] ADDR_MODE_CONTROL = 16'hff49; // watch_mode_control, whole byte
   localparam logic [15:0] ADDR_MODE_BIT     = 16'hff4a; // watch_mode_control, one bit
   localparam logic [15:0] ADDR_STATUS       = 16'hff4b; // flag and counter state

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
   localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int WATCH_CLOCK_SOURCE_SEL = 4; // 0: main clock / 2^8, 1: subsystem clock
   localparam int MODE_FAST              = 0; // Counter stepped by 2^5 tap
   localparam int PRESCALER_ENABLE       = 1;
   localparam int COUNTER_ENABLE         = 2;
   localparam int PERIOD_SEL             = 3; // 0: 2^14, 1: 2^13 watch clocks in normal mode; 0: 2^10, 1: 2^9 in fast mode
   localparam int INTERVAL_SEL_LSB       = 4;
   localparam int INTERVAL_SEL_MSB       = 6;
   localparam logic [7:0] MODE_WRITE_MASK = 8'h7f; // Bit 7 reads as zero
   localparam int BIT_WRITE_VALUE        = 3; // Data bit carrying the value in a bit write
   localparam int STATUS_FLAG            = 0; // Write 1 clears the watch flag
   localparam int STATUS_COUNT_LSB       = 3;

   // ***************************************************************
   // Divider and counter sizes
   // ***************************************************************
   localparam int MAIN_DIV_BITS   = 8;  // Main clock divided by 2^8
   localparam int PRESCALER_BITS  = 9;  // Final output at 2^9 watch clocks
   localparam int TAP_FIRST       = 4;  // First interval tap is 2^4
   localparam int TAP_COUNT       = 6;  // Taps 2^4 .. 2^9
   localparam int COUNTER_BITS    = 5;
   localparam int SHORT_BITS      = 4;  // Wrap of low 4 bits gives 2^13
   localparam logic [2:0] INTERVAL_LAST_CODE = 3'h5; // Codes above are prohibited

   // ***************************************************************
   // Clock
   // ***************************************************************
   localparam int CLK_HZ = 125_000_000; // CLK is the main clock

endpackage

// >>> design/watch_prescaler.sv
// Watch-clock prescaler with its interval taps
`timescale 1ns/100ps
`default_nettype none

module watch_prescaler (
   input  wire logic                                   CLK,
   input  wire logic                                   RST_B,
   input  wire logic                                   RUN,
   input  wire logic                                   TICK,
   output var  logic [watch_pkg::PRESCALER_BITS-1:0]    COUNT,
   output var  logic [watch_pkg::TAP_COUNT-1:0]         TAP,
   output var  logic                                   CARRY
);

   typedef struct packed {
      logic [watch_pkg::PRESCALER_BITS-1:0] count;
   } presc_s;

   presc_s cur;
   presc_s next;

   // Divide continuously; disabled prescaler is held cleared
   always_comb begin
      next = cur;
      if (!RUN) begin
         next.count = '0;
      end else if (TICK) begin
         next.count = cur.count + 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cur <= '0;
      end else begin
         cur <= next;
      end
   end

   // Tap i fires on the tick that completes 2^(i+4) watch clocks
   genvar i;
   generate
      for (i = 0; i < watch_pkg::TAP_COUNT; i++) begin : g_tap
         assign TAP[i] = RUN & TICK & (&cur.count[i+watch_pkg::TAP_FIRST-1:0]);
      end
   endgenerate

   assign COUNT = cur.count;
   assign CARRY = TAP[watch_pkg::TAP_COUNT-1];

   // ***************************************************************
   // Checks
   // ***************************************************************
   AST_PRESC_HELD: assert property (@(posedge CLK) disable iff (!RST_B)
      !RUN |=> COUNT == '0) else $error("prescaler not held cleared");
   AST_PRESC_CARRY: assert property (@(posedge CLK) disable iff (!RST_B)
      CARRY |=> COUNT == '0) else $error("carry without wrap");

endmodule
`default_nettype wire

// >>> design/watch_counter.sv
// Five-bit watch counter that produces the watch period
`timescale 1ns/100ps
`default_nettype none

module watch_counter (
   input  wire logic                                 CLK,
   input  wire logic                                 RST_B,
   input  wire logic                                 ENABLE,
   input  wire logic                                 STEP,
   input  wire logic                                 SHORT,
   output var  logic [watch_pkg::COUNTER_BITS-1:0]    COUNT,
   output var  logic                                 DONE
);

   typedef struct packed {
      logic [watch_pkg::COUNTER_BITS-1:0] count;
   } cnt_s;

   cnt_s cur;
   cnt_s next;

   // Counter is cleared and stopped while disabled
   always_comb begin
      next = cur;
      if (!ENABLE) begin
         next.count = '0;
      end else if (STEP) begin
         next.count = cur.count + 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cur <= '0;
      end else begin
         cur <= next;
      end
   end

   // Terminal count: full wrap, or wrap of the low bits for the short period
   assign DONE = ENABLE & STEP & (SHORT ? (&cur.count[watch_pkg::SHORT_BITS-1:0])
                                        : (&cur.count));
   assign COUNT = cur.count;

   // ***************************************************************
   // Checks
   // ***************************************************************
   AST_COUNTER_HELD: assert property (@(posedge CLK) disable iff (!RST_B)
      !ENABLE |=> COUNT == '0 && !DONE) else $error("counter runs while disabled");
   AST_COUNTER_STILL: assert property (@(posedge CLK) disable iff (!RST_B)
      ENABLE && !STEP |=> $stable(COUNT)) else $error("counter moved without step");

endmodule
`default_nettype wire

// >>> design/watch_timer.sv
// Watch timer top: registers, clock source, watch flag and interval request
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Watch and interval functions share one clock
// - Subsystem clock gives half or quarter second
// - Fast main clock: half or quarter second
// - Slow main clock: half or one second
// - Half second is 2^14 subsystem clocks
// - Source bit: main/2^8 or subsystem clock
// - Interval request repeats every interval
// - Three-bit code picks 2^4..2^9; rest prohibited
// - Mode register: mode, period, interval, enables
// - Watch period elapsed sets watch flag
// - Watch flag releases stop and halt
// - Counter enable low clears, stops counter
// - Clearing counter enable restarts from zero
// - Clock select written whole, resets zero
// - Mode register takes bit and byte writes
// - Mode register resets zero, all disabled
module watch_timer (
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic [15:0] ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output var  logic [7:0]  RDATA,
   input  wire logic        SUB_CLK,
   output var  logic        WATCH_FLAG,
   output var  logic        STANDBY_RELEASE,
   output var  logic        INTERVAL_IRQ
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [7:0]                          clock_select;
      logic [7:0]                          mode_control;
      logic [7:0]                          rdata;
      logic                                flag;
      logic                                wake;
      logic                                irq;
      logic                                sub_meta;
      logic                                sub_sync;
      logic                                sub_prev;
      logic [watch_pkg::MAIN_DIV_BITS-1:0] main_div;
   } top_s;

   top_s cur;
   top_s next;

   logic                                   watch_tick;
   logic                                   presc_run;
   logic                                   counter_run;
   logic                                   period_short;
   logic                                   fast_mode;
   logic [2:0]                             interval_sel;
   logic [watch_pkg::TAP_COUNT-1:0]        tap;
   logic                                   presc_carry;
   logic                                   counter_step;
   logic [watch_pkg::COUNTER_BITS-1:0]     counter_count;
   logic                                   counter_done;
   logic                                   interval_hit;
   logic                                   main_tick;
   logic                                   sub_tick;
   logic                                   wr_select;
   logic                                   wr_mode;
   logic                                   wr_bit;
   logic                                   wr_status;

   // ***************************************************************
   // Decoded controls
   // ***************************************************************

   // Fields of the mode register
   assign presc_run    = cur.mode_control[watch_pkg::PRESCALER_ENABLE];
   assign counter_run  = cur.mode_control[watch_pkg::COUNTER_ENABLE];
   assign period_short = cur.mode_control[watch_pkg::PERIOD_SEL];
   assign fast_mode    = cur.mode_control[watch_pkg::MODE_FAST];
   assign interval_sel = cur.mode_control[watch_pkg::INTERVAL_SEL_MSB:
                                          watch_pkg::INTERVAL_SEL_LSB];

   // Write strobes per register
   assign wr_select = WR && (ADDR == watch_pkg::ADDR_CLOCK_SELECT);
   assign wr_mode   = WR && (ADDR == watch_pkg::ADDR_MODE_CONTROL);
   assign wr_bit    = WR && (ADDR == watch_pkg::ADDR_MODE_BIT);
   assign wr_status = WR && (ADDR == watch_pkg::ADDR_STATUS);

   // ***************************************************************
   // Watch clock source
   // ***************************************************************

   // One enable per main clock / 2^8 or per synchronised subsystem rising edge
   assign main_tick  = &cur.main_div;
   assign sub_tick   = cur.sub_sync & ~cur.sub_prev;
   assign watch_tick = cur.clock_select[watch_pkg::WATCH_CLOCK_SOURCE_SEL]
                       ? sub_tick : main_tick;

   // ***************************************************************
   // Prescaler and counter
   // ***************************************************************

   // One prescaler serves both functions at once
   watch_prescaler u_prescaler (
      .CLK   (CLK),
      .RST_B (RST_B),
      .RUN   (presc_run),
      .TICK  (watch_tick),
      .COUNT (),
      .TAP   (tap),
      .CARRY (presc_carry)
   );

   // Normal mode steps the counter every 2^9 watch clocks
   assign counter_step = fast_mode ? tap[1] : presc_carry;

   // 2^9 x 2^5 = 2^14 or 2^9 x 2^4 = 2^13 watch clocks per flag
   watch_counter u_counter (
      .CLK   (CLK),
      .RST_B (RST_B),
      .ENABLE(counter_run),
      .STEP  (counter_step),
      .SHORT (period_short),
      .COUNT (counter_count),
      .DONE  (counter_done)
   );

   // Selected tap; prohibited codes never fire
   always_comb begin
      interval_hit = 1'b0;
      if (interval_sel <= watch_pkg::INTERVAL_LAST_CODE) begin
         interval_hit = tap[interval_sel];
      end
   end

   // ***************************************************************
   // Register, flag and output update
   // ***************************************************************

   // Next-state logic for all top-level state
   always_comb begin
      next = cur;

      // Source synchroniser; first stage feeds only the second
      next.sub_meta = SUB_CLK;
      next.sub_sync = cur.sub_meta;
      next.sub_prev = cur.sub_sync;
      next.main_div = cur.main_div + 1'b1;

      // Clock select only as a whole byte
      if (wr_select) begin
         next.clock_select = WDATA;
      end

      // Mode control by byte or by single bit
      if (wr_mode) begin
         next.mode_control = WDATA & watch_pkg::MODE_WRITE_MASK;
      end else if (wr_bit) begin
         next.mode_control[WDATA[watch_pkg::BIT_WRITE_VALUE-1:0]] =
            WDATA[watch_pkg::BIT_WRITE_VALUE];
         next.mode_control = next.mode_control & watch_pkg::MODE_WRITE_MASK;
      end

      // Watch flag: write one clears, a new set wins
      if (wr_status && WDATA[watch_pkg::STATUS_FLAG]) begin
         next.flag = 1'b0;
      end
      if (counter_done) begin
         next.flag = 1'b1;
      end

      // Standby release pulse and interval request pulse
      next.wake = counter_done;
      next.irq  = interval_hit;

      // Read data for the cycle after the strobe; unmapped reads zero
      next.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            watch_pkg::ADDR_CLOCK_SELECT: next.rdata = cur.clock_select;
            watch_pkg::ADDR_MODE_CONTROL: next.rdata = cur.mode_control;
            watch_pkg::ADDR_MODE_BIT:     next.rdata = cur.mode_control;
            watch_pkg::ADDR_STATUS: begin
               next.rdata[watch_pkg::STATUS_FLAG] = cur.flag;
               next.rdata[watch_pkg::STATUS_COUNT_LSB +: watch_pkg::COUNTER_BITS] =
                  counter_count;
            end
            default: next.rdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cur              <= '0;
         cur.clock_select <= watch_pkg::CLOCK_SELECT_RESET;
         cur.mode_control <= watch_pkg::MODE_CONTROL_RESET;
      end else begin
         cur <= next;
      end
   end

   // Outputs straight from flip-flops
   assign RDATA           = cur.rdata;
   assign WATCH_FLAG      = cur.flag;
   assign STANDBY_RELEASE = cur.wake;
   assign INTERVAL_IRQ    = cur.irq;

   // ***************************************************************
   // Checks
   // ***************************************************************

   sequence s_select_write;
      wr_select;
   endsequence

   sequence s_bit_write;
      wr_bit && WDATA[2:0] < 3'h7;
   endsequence

   sequence s_flag_clear;
      wr_status && WDATA[watch_pkg::STATUS_FLAG] && !counter_done;
   endsequence

   AST_RESET_ZERO: assert property (@(posedge CLK)
      !RST_B |=> cur.mode_control == watch_pkg::MODE_CONTROL_RESET &&
                 cur.clock_select == watch_pkg::CLOCK_SELECT_RESET &&
                 !WATCH_FLAG && !INTERVAL_IRQ)
      else $error("registers not cleared by reset");

   AST_SELECT_WRITE: assert property (@(posedge CLK) disable iff (!RST_B)
      s_select_write |=> cur.clock_select == $past(WDATA))
      else $error("clock select write lost");

   AST_BIT_WRITE: assert property (@(posedge CLK) disable iff (!RST_B)
      s_bit_write |=> cur.mode_control[$past(WDATA[2:0])] ==
                      $past(WDATA[watch_pkg::BIT_WRITE_VALUE]))
      else $error("single-bit write lost");

   AST_FLAG_SET: assert property (@(posedge CLK) disable iff (!RST_B)
      counter_done |=> WATCH_FLAG && STANDBY_RELEASE)
      else $error("watch flag not set at period end");

   AST_FLAG_CLEAR: assert property (@(posedge CLK) disable iff (!RST_B)
      s_flag_clear |=> !WATCH_FLAG)
      else $error("watch flag not cleared");

   AST_WAKE_CAUSE: assert property (@(posedge CLK) disable iff (!RST_B)
      STANDBY_RELEASE |-> $past(counter_done) && WATCH_FLAG)
      else $error("standby release without watch flag");

   AST_IRQ_TAP: assert property (@(posedge CLK) disable iff (!RST_B)
      interval_sel <= watch_pkg::INTERVAL_LAST_CODE && tap[interval_sel] |=> INTERVAL_IRQ)
      else $error("interval request missed");

   AST_IRQ_PROHIBITED: assert property (@(posedge CLK) disable iff (!RST_B)
      interval_sel > watch_pkg::INTERVAL_LAST_CODE |=> !INTERVAL_IRQ)
      else $error("interval request on prohibited code");

   AST_MAIN_SOURCE: assert property (@(posedge CLK) disable iff (!RST_B)
      !cur.clock_select[watch_pkg::WATCH_CLOCK_SOURCE_SEL] && watch_tick
      |-> cur.main_div == '1)
      else $error("main source tick off the divider");

   AST_RESTART: assert property (@(posedge CLK) disable iff (!RST_B)
      counter_run ##1 !counter_run |=> counter_count == '0 && presc_run == $past(presc_run))
      else $error("counter restart disturbed");

endmodule
`default_nettype wire

// >>> tb/test_watch_timer.sv
// Self-checking bench for the watch timer
`timescale 1ns/100ps
`default_nettype none

module test_watch_timer;
   logic        CLK;
   logic        RST_B;
   logic [15:0] ADDR;
   logic [7:0]  WDATA;
   logic        WR;
   logic        RD;
   logic [7:0]  RDATA;
   logic        SUB_CLK;
   logic        WATCH_FLAG;
   logic        STANDBY_RELEASE;
   logic        INTERVAL_IRQ;
   logic [1:0]  sub_div;
   logic [31:0] seed;
   logic        flag_was;
   int          fail_count;
   int          check_count;
   int          cyc;
   int          irq_n;
   int          irq_at;
   int          irq_gap;
   int          flag_at;
   int          rel_n;

   watch_timer dut_u (
      .CLK             (CLK),
      .RST_B           (RST_B),
      .ADDR            (ADDR),
      .WDATA           (WDATA),
      .WR              (WR),
      .RD              (RD),
      .RDATA           (RDATA),
      .SUB_CLK         (SUB_CLK),
      .WATCH_FLAG      (WATCH_FLAG),
      .STANDBY_RELEASE (STANDBY_RELEASE),
      .INTERVAL_IRQ    (INTERVAL_IRQ)
   );

   // ***************************************************************
   // Clocks and monitors
   // ***************************************************************
   // Main clock, 8 ns period
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   // Subsystem clock, four main clocks per period
   always @(posedge CLK) begin
      if (!RST_B) begin
         sub_div <= 2'b00;
      end else begin
         sub_div <= sub_div + 2'd1;
      end
      SUB_CLK <= sub_div[1];
   end

   // Cycle count, interval gaps and flag rise, sampled mid-cycle
   always @(negedge CLK) begin
      cyc++;
      if (INTERVAL_IRQ === 1'b1) begin
         irq_gap = cyc - irq_at;
         irq_at  = cyc;
         irq_n++;
      end
      if (STANDBY_RELEASE === 1'b1) rel_n++;
      if (WATCH_FLAG === 1'b1 && !flag_was) begin
         flag_at = cyc;
         chk_bit(STANDBY_RELEASE, 1'b1);
      end
      flag_was = (WATCH_FLAG === 1'b1);
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected interval gap in main clocks
   function automatic int gap_of(input int code, input int div);
      return (1 << (code + 4)) * div;
   endfunction

   function automatic logic [7:0] mode_of(input int code, input logic [7:0] en);
      return 8'(code << 4) | en;
   endfunction

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic chk_num(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("MISMATCH t=%0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK);
      WR    <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK);
      RD   <= 1'b0;
      @(negedge CLK);
      d = RDATA;
      @(posedge CLK);
   endtask

   task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk_byte(d, exp);
   endtask

   // Wait for k more interval requests, bounded
   task automatic wait_irq(input int k, input int lim);
      int n0;
      n0 = irq_n;
      while (irq_n < n0 + k && lim > 0) begin
         @(posedge CLK);
         lim--;
      end
      if (irq_n < n0 + k) chk_bit(1'b0, 1'b1);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Watchdog over the whole run
   initial begin
      repeat (100000) @(posedge CLK);
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish();
   end

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      logic [7:0] exp;
      logic [7:0] d;
      logic [7:0] cs;
      int         t0;
      RST_B = 1'b0;
      ADDR = 16'h0000;
      WDATA = 8'h00;
      WR = 1'b0;
      RD = 1'b0;
      seed = 32'h0b95_07cf;
      flag_was = 1'b0;
      fail_count = 0;
      check_count = 0;
      cyc = 0;
      irq_n = 0;
      irq_at = 0;
      irq_gap = 0;
      flag_at = -1;
      rel_n = 0;
      repeat (3) @(posedge CLK);
      RST_B <= 1'b1;
      // Reset values and idle outputs
      rchk(watch_pkg::ADDR_CLOCK_SELECT, 8'h00);
      rchk(watch_pkg::ADDR_MODE_CONTROL, 8'h00);
      rchk(watch_pkg::ADDR_STATUS, 8'h00);
      repeat (600) @(posedge CLK);
      chk_num(irq_n, 0, 0);
      chk_bit(WATCH_FLAG, 1'b0);
      $display("test reset done");
      // Random byte writes, unmapped place, bit writes
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(watch_pkg::ADDR_CLOCK_SELECT, seed[7:0]);
         rchk(watch_pkg::ADDR_CLOCK_SELECT, seed[7:0]);
         wr(watch_pkg::ADDR_MODE_CONTROL, seed[15:8]);
         rchk(watch_pkg::ADDR_MODE_CONTROL, seed[15:8] & 8'h7f);
      end
      wr(16'hff4c, 8'hff);
      rchk(16'hff4c, 8'h00);
      wr(watch_pkg::ADDR_MODE_CONTROL, 8'h00);
      exp = 8'h00;
      for (int i = 0; i < 16; i++) begin
         wr(watch_pkg::ADDR_MODE_BIT, 8'(((i < 8) ? 8 : 0) | (i % 8)));
         exp[i % 8] = (i < 8);
         rchk(watch_pkg::ADDR_MODE_CONTROL, exp & 8'h7f);
      end
      $display("test registers done");
      // Interval taps from the subsystem clock, timers stopped first
      seed = lfsr(seed);
      cs = {seed[7:5], 1'b1, seed[3:0]};
      wr(watch_pkg::ADDR_CLOCK_SELECT, cs);
      for (int c = 0; c < 6; c++) begin
         wr(watch_pkg::ADDR_MODE_CONTROL, mode_of(c, 8'h02));
         wait_irq(1, 3000);
         wait_irq(1, 3000);
         chk_num(irq_gap, gap_of(c, 4), gap_of(c, 4));
      end
      for (int c = 6; c < 8; c++) begin
         wr(watch_pkg::ADDR_MODE_CONTROL, mode_of(c, 8'h02));
         t0 = irq_n;
         repeat (2100) @(posedge CLK);
         chk_num(irq_n, t0, t0);
      end
      $display("test interval done");
      // Main clock divided by 2^8 as source
      wr(watch_pkg::ADDR_MODE_CONTROL, 8'h00);
      wr(watch_pkg::ADDR_CLOCK_SELECT, cs & 8'hef);
      wr(watch_pkg::ADDR_MODE_CONTROL, mode_of(0, 8'h02));
      wait_irq(1, 4500);
      wait_irq(1, 4500);
      chk_num(irq_gap, gap_of(0, 256), gap_of(0, 256));
      $display("test main source done");
      // Counter clear, zero-second start and watch flag
      wr(watch_pkg::ADDR_MODE_CONTROL, 8'h00);
      wr(watch_pkg::ADDR_CLOCK_SELECT, cs);
      wr(watch_pkg::ADDR_MODE_CONTROL, mode_of(5, 8'h06));
      repeat (2200) @(posedge CLK);
      rd(watch_pkg::ADDR_STATUS, d);
      chk_bit(d[7:3] != 5'd0, 1'b1);
      wr(watch_pkg::ADDR_MODE_BIT, 8'h02);
      rchk(watch_pkg::ADDR_STATUS, 8'h00);
      t0 = irq_n;
      repeat (2100) @(posedge CLK);
      rchk(watch_pkg::ADDR_STATUS, 8'h00);
      chk_num(irq_n, t0 + 1, t0 + 2);
      flag_at = -1;
      wr(watch_pkg::ADDR_MODE_BIT, 8'h0a);
      t0 = cyc;
      while (flag_at < 0 && cyc - t0 < 70000) @(posedge CLK);
      chk_num(flag_at - t0, 16384 * 4 - 2048 - 4, 16384 * 4 + 8);
      repeat (4) @(posedge CLK);
      chk_bit(WATCH_FLAG, 1'b1);
      chk_num(rel_n, 1, 1);
      rd(watch_pkg::ADDR_STATUS, d);
      chk_bit(d[0], 1'b1);
      wr(watch_pkg::ADDR_STATUS, 8'h01);
      rd(watch_pkg::ADDR_STATUS, d);
      chk_bit(d[0], 1'b0);
      chk_bit(WATCH_FLAG, 1'b0);
      $display("test watch flag done");
      // Fast mode, short period: 2^5 x 2^4 watch clocks per flag
      flag_at = -1;
      wr(watch_pkg::ADDR_MODE_CONTROL, mode_of(5, 8'h02));
      wr(watch_pkg::ADDR_MODE_CONTROL, mode_of(5, 8'h0f));
      t0 = cyc;
      while (flag_at < 0 && cyc - t0 < 3000) @(posedge CLK);
      chk_num(flag_at - t0, 2048 - 128 - 4, 2048 + 8);
      chk_num(rel_n, 2, 2);
      $display("test fast period done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
